// *** rtl/presence_cfg.svh ***
// constants for the drive presence, strap and pin-sharing block
`ifndef PRESENCE_CFG_SVH
`define PRESENCE_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLOCK_HZ 20000000
`define CYC_PER_MS (`CLOCK_HZ / 1000)
`define SLAVE_ASSERT_MS 400
`define MASTER_WAIT_MS 450
`define SLAVE_HOLD_S 31
`define SLAVE_ASSERT_CYC (`SLAVE_ASSERT_MS * `CYC_PER_MS)
`define MASTER_WAIT_CYC (`MASTER_WAIT_MS * `CYC_PER_MS)
`define SLAVE_HOLD_CYC (`SLAVE_HOLD_S * `CLOCK_HZ)
`define TIMER_W 30

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define CTRL_SPIN_BIT 0
`define CTRL_FLOAT_BIT 1
`define CTRL_FLOAT_RESET 1'h0
`define STAT_MASTER_BIT 0
`define STAT_DETECT_BIT 1
`define STAT_PRESENCE_BIT 2
`define STAT_SPIN_BIT 3
`define STAT_INHIBIT_BIT 4
`define STAT_WINDOW_BIT 5
`define STAT_FUNC_LSB 6
`define STAT_FLOAT_BIT 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** rtl/presence_pkg.sv ***
// types shared by the presence block and its timer
`include "presence_cfg.svh"

package presence_pkg;

	// ----------------------------------------------------------------
	// phases and pin functions
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_STRAP, ST_PRESENCE, ST_OPERATE} phase_t;
	typedef enum logic [1:0] {PIN_FLOAT, PIN_ACTIVITY, PIN_SYNC} pin_func_t;

	// ----------------------------------------------------------------
	// state records
	// ----------------------------------------------------------------
	typedef struct packed {
		phase_t phase;
		logic presence;
		logic isMaster;
		pin_func_t pinFunc;
		logic inhibitStrap;
		logic slaveDetected;
		logic spindleRun;
		logic pinFloat;
		logic timerClear;
		logic [`TIMER_W-1:0] timerLimit;
		logic lineOut;
		logic lineOe;
		logic awReady;
		logic wReady;
		logic haveAw;
		logic haveW;
		logic [31:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} presence_state_t;

	typedef struct packed {
		logic [`TIMER_W-1:0] count;
		logic expired;
	} timer_state_t;

endpackage

// *** rtl/interval_timer.sv ***
// cycle counter that flags when a loaded limit has elapsed
`timescale 1ns/100ps
`include "presence_cfg.svh"

module interval_timer
	import presence_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rstSync_n, // synchronised reset, active low
	input wire logic clear, // hold count at zero
	input wire logic [`TIMER_W-1:0] limit, // cycles until expiry
	output logic expired // limit reached, held until clear
);

	timer_state_t s_q;
	timer_state_t s_d;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (clear) begin
			s_d.count = '0;
			s_d.expired = 1'b0;
		end else if (!s_q.expired) begin
			s_d.count = s_q.count + 1'b1;
			s_d.expired = (s_d.count >= limit);
		end
	end

	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired = s_q.expired;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_expire_at_limit;
		@(posedge clock) disable iff (!rstSync_n)
		(!clear && !s_q.expired && s_q.count + 1'b1 == limit) |=> expired;
	endproperty
	a_expire_at_limit: assert property (p_expire_at_limit)
		else $error("timer missed its limit");

	property p_no_early_expiry;
		@(posedge clock) disable iff (!rstSync_n)
		$rose(expired) |-> (s_q.count >= limit && !$past(clear));
	endproperty
	a_no_early_expiry: assert property (p_no_early_expiry)
		else $error("timer expired before its limit");

endmodule

// *** rtl/drive_presence_config.sv ***
// strap capture, slave presence handshake and shared pin control
`timescale 1ns/100ps
`include "presence_cfg.svh"

module drive_presence_config
	import presence_pkg::*;
#(
	parameter int MASTER_WAIT_CYCLES = `MASTER_WAIT_CYC, // master window
	parameter int SLAVE_HOLD_CYCLES = `SLAVE_HOLD_CYC // slave hold limit
) (
	input wire logic clock, // 20 MHz system clock
	input wire logic reset_n, // power-on or hardware reset, active low
	input wire logic masterSelJumper, // role strap installed
	input wire logic activityLedJumper, // activity strap installed
	input wire logic spindleSyncJumper, // sync strap installed
	input wire logic spinupInhibitJumper, // spin-up inhibit strap installed
	input wire logic slavePresentActivityLineIn, // shared line level
	output logic slavePresentActivityLineOut, // shared line drive level
	output logic slavePresentActivityLineOe, // shared line enable
	input wire logic driveActivity, // drive busy indication
	input wire logic spindleSyncIn, // spindle sync from motor logic
	input wire logic cmdAccept, // valid command accepted, pulse
	input wire logic cmdMediaAccess, // accepted command needs media
	output logic spindleRun, // spindle motor enable
	output logic slaveDetected, // master saw a slave
	output logic presenceActive, // presence phase in progress
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] awaddr, // write address
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte strobes
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	output logic [1:0] bresp, // write response
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	input wire logic [31:0] araddr, // read address
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp // read response
);

	// ----------------------------------------------------------------
	// reset synchroniser
	// ----------------------------------------------------------------
	logic [1:0] rstPipe_q;
	logic rstSync_n;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end

	assign rstSync_n = rstPipe_q[1];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(logic [31:0] addr);
		return ({addr[31:2], 2'b00} == `REG_CTRL) || ({addr[31:2], 2'b00} == `REG_STATUS);
	endfunction

	function automatic logic [31:0] read_word(logic [31:0] addr, presence_state_t st,
		logic window);
		logic [31:0] w;
		w = 32'h0000_0000;
		if ({addr[31:2], 2'b00} == `REG_CTRL) begin
			w[`CTRL_FLOAT_BIT] = st.pinFloat;
		end else if ({addr[31:2], 2'b00} == `REG_STATUS) begin
			w[`STAT_MASTER_BIT] = st.isMaster;
			w[`STAT_DETECT_BIT] = st.slaveDetected;
			w[`STAT_PRESENCE_BIT] = (st.phase == ST_PRESENCE);
			w[`STAT_SPIN_BIT] = st.spindleRun;
			w[`STAT_INHIBIT_BIT] = st.inhibitStrap;
			w[`STAT_WINDOW_BIT] = window;
			w[`STAT_FUNC_LSB +: 2] = st.pinFunc;
			w[`STAT_FLOAT_BIT] = st.pinFloat;
		end
		return w;
	endfunction

	// {level, enable} for the shared line
	function automatic logic [1:0] pin_drive(presence_state_t st, logic act, logic sync);
		logic [1:0] r;
		r = 2'b10;
		if (st.phase == ST_PRESENCE) begin
			r = st.isMaster ? 2'b10 : 2'b01;
		end else if (st.phase == ST_OPERATE && !st.pinFloat) begin
			case (st.pinFunc)
				PIN_ACTIVITY: r = {~act, 1'b1};
				PIN_SYNC: r = {sync, 1'b1};
				default: r = 2'b10;
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	presence_state_t s_q;
	presence_state_t s_d;
	logic timerExpired;
	logic awTake;
	logic wTake;
	logic arTake;

	interval_timer i_interval_timer (
		.clock(clock),
		.rstSync_n(rstSync_n),
		.clear(s_q.timerClear),
		.limit(s_q.timerLimit),
		.expired(timerExpired)
	);

	always_comb begin
		s_d = s_q;
		awTake = awvalid && s_q.awReady;
		wTake = wvalid && s_q.wReady;
		arTake = arvalid && s_q.arReady;

		unique case (s_q.phase)
			ST_STRAP: begin
				s_d.isMaster = masterSelJumper;
				if (spindleSyncJumper) begin
					s_d.pinFunc = PIN_SYNC;
				end else if (activityLedJumper) begin
					s_d.pinFunc = PIN_ACTIVITY;
				end else begin
					s_d.pinFunc = PIN_FLOAT;
				end
				s_d.inhibitStrap = spinupInhibitJumper;
				s_d.spindleRun = !spinupInhibitJumper;
				s_d.timerClear = 1'b1;
				s_d.timerLimit = masterSelJumper ? `TIMER_W'(MASTER_WAIT_CYCLES)
					: `TIMER_W'(SLAVE_HOLD_CYCLES);
				s_d.phase = ST_PRESENCE;
			end
			ST_PRESENCE: begin
				s_d.timerClear = 1'b0;
				if (s_q.isMaster) begin
					if (!slavePresentActivityLineIn) begin
						s_d.slaveDetected = 1'b1;
					end
					if (timerExpired) begin
						s_d.phase = ST_OPERATE;
					end
				end else begin
					if (cmdAccept || timerExpired) begin
						s_d.phase = ST_OPERATE;
					end
				end
			end
			ST_OPERATE: s_d.timerClear = 1'b1;
			// illegal code falls back to strap sampling
			default: s_d.phase = ST_STRAP;
		endcase

		if (s_q.phase != ST_STRAP && cmdAccept && cmdMediaAccess) begin
			s_d.spindleRun = 1'b1;
		end

		// write channel
		if (awTake) begin
			s_d.haveAw = 1'b1;
			s_d.awAddr = awaddr;
		end
		if (wTake) begin
			s_d.haveW = 1'b1;
			s_d.wData = wdata;
			s_d.wStrb = wstrb;
		end
		if (s_q.bValid && bready) begin
			s_d.bValid = 1'b0;
		end
		if (s_d.haveAw && s_d.haveW && !s_d.bValid) begin
			s_d.haveAw = 1'b0;
			s_d.haveW = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp = reg_hit(s_d.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
			if ({s_d.awAddr[31:2], 2'b00} == `REG_CTRL && s_d.wStrb[0]) begin
				s_d.pinFloat = s_d.wData[`CTRL_FLOAT_BIT];
				if (s_d.wData[`CTRL_SPIN_BIT]) begin
					s_d.spindleRun = 1'b1;
				end
			end
		end
		s_d.awReady = !s_d.haveAw && !s_d.bValid;
		s_d.wReady = !s_d.haveW && !s_d.bValid;

		// read channel
		if (s_q.rValid && rready) begin
			s_d.rValid = 1'b0;
		end
		if (arTake) begin
			s_d.rValid = 1'b1;
			s_d.rData = read_word(araddr, s_q, timerExpired);
			s_d.rResp = reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		s_d.arReady = !s_d.rValid;

		s_d.presence = (s_d.phase == ST_PRESENCE);
		{s_d.lineOut, s_d.lineOe} = pin_drive(s_d, driveActivity, spindleSyncIn);
	end

	always_ff @(posedge clock or negedge rstSync_n) begin
		if (!rstSync_n) begin
			s_q <= '0;
			s_q.timerClear <= 1'b1;
			s_q.lineOut <= 1'b1;
			s_q.pinFloat <= `CTRL_FLOAT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign slavePresentActivityLineOut = s_q.lineOut;
	assign slavePresentActivityLineOe = s_q.lineOe;
	assign spindleRun = s_q.spindleRun;
	assign slaveDetected = s_q.slaveDetected;
	assign presenceActive = s_q.presence;
	assign awready = s_q.awReady;
	assign wready = s_q.wReady;
	assign bvalid = s_q.bValid;
	assign bresp = s_q.bResp;
	assign arready = s_q.arReady;
	assign rvalid = s_q.rValid;
	assign rdata = s_q.rData;
	assign rresp = s_q.rResp;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstSync_n);

	sequence s_strap_cycle;
		s_q.phase == ST_STRAP && rstSync_n;
	endsequence

	sequence s_slave_strap;
		s_strap_cycle ##0 !masterSelJumper;
	endsequence

	sequence s_slave_leave;
		s_q.phase == ST_PRESENCE && !s_q.isMaster && (cmdAccept || timerExpired);
	endsequence

	property p_role;
		s_strap_cycle |=> s_q.isMaster == $past(masterSelJumper);
	endproperty
	a_role: assert property (p_role)
		else $error("role does not follow strap");

	property p_master_quiet;
		(presenceActive && s_q.isMaster) |-> !slavePresentActivityLineOe;
	endproperty
	a_master_quiet: assert property (p_master_quiet)
		else $error("master drives line in window");

	property p_slave_mark;
		(presenceActive && !s_q.isMaster)
			|-> (slavePresentActivityLineOe && !slavePresentActivityLineOut);
	endproperty
	a_slave_mark: assert property (p_slave_mark)
		else $error("slave not marking presence");

	property p_slave_soon;
		s_slave_strap |=> presenceActive ##0 slavePresentActivityLineOe
			##0 !slavePresentActivityLineOut;
	endproperty
	a_slave_soon: assert property (p_slave_soon)
		else $error("slave late to assert presence");

	property p_window;
		(presenceActive && s_q.isMaster && timerExpired)
			|=> (s_q.phase == ST_OPERATE) ##1 (s_q.phase == ST_OPERATE);
	endproperty
	a_window: assert property (p_window)
		else $error("master window did not close");

	property p_slave_release;
		s_slave_leave |=> !presenceActive;
	endproperty
	a_slave_release: assert property (p_slave_release)
		else $error("slave kept presence too long");

	property p_activity;
		(s_q.phase == ST_OPERATE && s_q.pinFunc == PIN_ACTIVITY && !s_q.pinFloat)
			|-> (slavePresentActivityLineOe
			&& slavePresentActivityLineOut == !$past(driveActivity));
	endproperty
	a_activity: assert property (p_activity)
		else $error("activity not on shared pin");

	property p_sync;
		(s_q.phase == ST_OPERATE && s_q.pinFunc == PIN_SYNC && !s_q.pinFloat)
			|-> (slavePresentActivityLineOe
			&& slavePresentActivityLineOut == $past(spindleSyncIn));
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync not on shared pin");

	property p_inhibit;
		(s_strap_cycle ##0 spinupInhibitJumper) |=> !spindleRun;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("spindle started despite inhibit");

	property p_media_start;
		(s_q.phase != ST_STRAP && cmdAccept && cmdMediaAccess)
			|=> spindleRun [*2];
	endproperty
	a_media_start: assert property (p_media_start)
		else $error("media command did not start spindle");

	property p_detect;
		(presenceActive && s_q.isMaster && !slavePresentActivityLineIn)
			|=> slaveDetected ##1 slaveDetected;
	endproperty
	a_detect: assert property (p_detect)
		else $error("slave presence not latched");

	property p_straps_held;
		(s_q.phase != ST_STRAP) |=> ($stable(s_q.isMaster) && $stable(s_q.pinFunc)
			&& $stable(s_q.inhibitStrap) && s_q.phase != ST_STRAP);
	endproperty
	a_straps_held: assert property (p_straps_held)
		else $error("straps changed after reset");

endmodule

// *** verification/peer_drive_model.sv ***
// peer drive on the shared presence line, acting as slave or absent
`timescale 1ns/100ps

module peer_drive_model (
	input wire logic clock, // system clock
	input wire logic reset_n, // shared reset, active low
	input wire logic actAsSlave, // peer holds the slave role
	input wire logic [7:0] assertDelay, // cycles before presence
	input wire logic [7:0] holdCycles, // cycles presence is held
	output logic lineOut, // level driven on shared line
	output logic lineOe // peer drives the shared line
);
	logic [8:0] count_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= 9'h000;
		end else if (count_q != 9'h1ff) begin
			count_q <= count_q + 9'h001;
		end
	end

	assign lineOe = actAsSlave && (count_q >= {1'h0, assertDelay})
		&& (count_q < ({1'h0, assertDelay} + {1'h0, holdCycles}));
	// released line falls back to the pull-up
	assign lineOut = 1'h0;
endmodule

// *** verification/drive_presence_config_tb_top.sv ***
// self-checking bench for the presence, strap and shared pin block
`timescale 1ns/100ps

module drive_presence_config_tb_top;
	typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} note_t;
	logic clock = 0, reset_n = 0, ms = 0, act = 0, ss = 0, inh = 0;
	logic dutOut, dutOe, peerOut, peerOe, lineLevel, peerSlave = 0;
	logic driveActivity = 0, spindleSyncIn = 0, cmdAccept = 0, cmdMedia = 0;
	logic spindleRun, slaveDetected, presenceActive;
	logic [7:0] peerDelay = 8'h05;
	logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic arvalid = 0, arready, rvalid, rready = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [3:0] wstrb = 0;
	logic [1:0] bresp, rresp;
	int fails = 0, checked = 0;
	logic [1:0] bQ[$];
	note_t rQ[$];

	// ----------------------------------------------------------------
	// design, peer and wired line
	// ----------------------------------------------------------------
	assign lineLevel = (dutOe ? dutOut : 1'h1) & (peerOe ? peerOut : 1'h1);
	drive_presence_config #(.MASTER_WAIT_CYCLES(20), .SLAVE_HOLD_CYCLES(50))
	i_drive_presence_config (.clock(clock), .reset_n(reset_n), .masterSelJumper(ms),
		.activityLedJumper(act), .spindleSyncJumper(ss), .spinupInhibitJumper(inh),
		.slavePresentActivityLineIn(lineLevel), .slavePresentActivityLineOut(dutOut),
		.slavePresentActivityLineOe(dutOe), .driveActivity(driveActivity),
		.spindleSyncIn(spindleSyncIn), .cmdAccept(cmdAccept), .cmdMediaAccess(cmdMedia),
		.spindleRun(spindleRun), .slaveDetected(slaveDetected),
		.presenceActive(presenceActive), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));
	peer_drive_model i_peer_drive_model (.clock(clock), .reset_n(reset_n),
		.actAsSlave(peerSlave), .assertDelay(peerDelay), .holdCycles(8'h08),
		.lineOut(peerOut), .lineOe(peerOe));

	initial begin
		forever #25 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// compare, verdict and bus tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, exp, mask, input string what);
		checked++;
		if ((got & mask) !== (exp & mask)) begin
			fails++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, exp, input string what);
		cmp_word({31'h0, got}, {31'h0, exp}, 32'hffff_ffff, what);
	endtask

	task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
		bit aw, w;
		aw = 0;
		w = 0;
		bQ.push_back(r);
		@(posedge clock);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= d;
		wstrb <= s;
		bready <= 1;
		while (!(aw && w)) begin
			@(posedge clock);
			if (awvalid && awready) begin
				aw = 1;
				awvalid <= 0;
			end
			if (wvalid && wready) begin
				w = 1;
				wvalid <= 0;
			end
		end
		while (!bvalid) @(posedge clock);
		bready <= 0;
	endtask

	task automatic axi_read(input logic [31:0] a, d, m, input logic [1:0] r);
		rQ.push_back('{d, m, r});
		@(posedge clock);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do @(posedge clock); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge clock);
		rready <= 0;
	endtask

	task automatic do_reset(input logic m, a, s, i, pS, input logic [7:0] pD);
		@(posedge clock);
		reset_n <= 0;
		{ms, act, ss, inh, peerSlave, peerDelay} <= {m, a, s, i, pS, pD};
		repeat (8) @(posedge clock);
		reset_n <= 1;
		repeat (4) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic pin_loop(input logic useSync);
		logic a, s;
		repeat (6) begin
			a = 1'($urandom);
			s = 1'($urandom);
			@(posedge clock);
			driveActivity <= a;
			spindleSyncIn <= s;
			repeat (2) @(posedge clock);
			@(negedge clock);
			cmp_bit(dutOe, 1'h1, "pin enable");
			cmp_bit(dutOut, useSync ? s : ~a, "pin level");
		end
	endtask

	task automatic command(input logic media);
		@(posedge clock);
		cmdAccept <= 1;
		cmdMedia <= media;
		@(posedge clock);
		cmdAccept <= 0;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask

	// ----------------------------------------------------------------
	// result monitor
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		note_t n;
		if (bvalid && bready && bQ.size() > 0) begin
			cmp_word({30'h0, bresp}, {30'h0, bQ.pop_front()}, 32'hffff_ffff, "bresp");
		end
		if (rvalid && rready && rQ.size() > 0) begin
			n = rQ.pop_front();
			cmp_word(rdata, n.data, n.mask, "rdata");
			cmp_word({30'h0, rresp}, {30'h0, n.resp}, 32'hffff_ffff, "rresp");
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hb1a6));
		do_reset(1, 1, 0, 0, 1, 8'($urandom_range(10, 2)));
		repeat (10) begin
			@(negedge clock);
			cmp_bit(dutOe, 1'h0, "master quiet in window");
		end
		repeat (15) @(negedge clock);
		cmp_bit(presenceActive, 1'h0, "window closed");
		cmp_bit(slaveDetected, 1'h1, "slave seen");
		@(posedge clock);
		{ms, act} <= 2'h0;
		pin_loop(0);
		axi_read(32'h0000_0004, 32'h0000_004b, 32'hffff_ffff, 2'h0);
		do_reset(1, 0, 0, 0, 0, 8'h00);
		repeat (25) @(negedge clock);
		cmp_bit(slaveDetected, 1'h0, "no slave");
		cmp_bit(dutOe, 1'h0, "pin floats");
		do_reset(1, 1, 1, 0, 1, 8'h23);
		repeat (40) @(negedge clock);
		cmp_bit(slaveDetected, 1'h0, "late presence ignored");
		pin_loop(1);
		do_reset(0, 1, 0, 1, 0, 8'h00);
		cmp_bit(presenceActive, 1'h1, "slave presence phase");
		cmp_bit(lineLevel, 1'h0, "slave asserts line");
		cmp_bit(spindleRun, 1'h0, "spin held off");
		command(0);
		cmp_bit(presenceActive, 1'h0, "released on command");
		cmp_bit(spindleRun, 1'h0, "no media, no spin");
		command(1);
		cmp_bit(spindleRun, 1'h1, "media command spins");
		pin_loop(0);
		do_reset(0, 0, 1, 1, 0, 8'h00);
		repeat (30) @(negedge clock);
		cmp_bit(presenceActive, 1'h1, "slave still holding");
		repeat (30) @(negedge clock);
		cmp_bit(presenceActive, 1'h0, "hold limit");
		cmp_bit(dutOe, 1'h1, "sync on pin");
		cmp_bit(spindleRun, 1'h0, "spin held off");
		axi_write(32'h0000_0000, 32'h0000_0001, 4'h1, 2'h0);
		axi_write(32'h0000_0000, 32'h0000_0002, 4'h1, 2'h0);
		axi_write(32'h0000_0000, 32'h0000_0000, 4'h0, 2'h0);
		axi_write(32'h0000_0004, 32'hffff_ffff, 4'hf, 2'h0);
		axi_write(32'h0000_0010, 32'h0000_0001, 4'hf, 2'h2);
		axi_read(32'h0000_0000, 32'h0000_0002, 32'hffff_ffff, 2'h0);
		axi_read(32'h0000_0010, 32'h0000_0000, 32'hffff_ffff, 2'h2);
		axi_read(32'h0000_0004, 32'h0000_0198, 32'hffff_ffff, 2'h0);
		repeat (3) @(negedge clock);
		cmp_bit(spindleRun, 1'h1, "register spin start");
		cmp_bit(dutOe, 1'h0, "pin released by float");
		print_verdict();
	end
endmodule
